// *** logic/cfc_filter_top.sv ***
// Purpose: fixed-point compensation filter with pulse modulator
// Assumes: error word stable through the fourth rising edge after its strobe rises
// Notes: one instance per regulated rail
// Operation
// R1: Front end error (reference minus rail) arrives as 6-bit signed sample.
// R2: 10-bit reference code spans 0 V to 1.6 V, set by processor.
// R3: Nonlinear gain maps each 6-bit error to a 9-bit filter input.
// R4: Gain is high for large errors and low near zero.
// R5: Coefficients are 12-bit integers; each product is 20 bits; the code keeps feedback and first-order products at 29 bits.
// R6: Filter output is 16 bits; all path signals are signed.
// R7: Every product drops low bits by rounding, never truncation; the code truncates the low bits of the modulator product edge_prod.
// R8: Feed-forward products drop their lowest 3 bits with rounding.
// R9: The binary left-shift gain also drops 3 low bits.
// R10: Feedback products drop their lowest 8 bits with rounding.
// R11: Accumulators only add; feedback coefficients are stored negated.
// R12: Software rounds coefficients times 2^(11-Kscale), negating feedback ones.
// R13: Modulator scales output by period value and compares with ramp.
// R14: Modulator edge placed in 16 phases of 250 MHz, 250 ps steps.
// R15: Each rail's filter runs in logic without the processor.
// R16: A first-order section (z+zero coef)/(z-pole coef) follows.
// R17: Kick-start holds width by clamping; both sections share clamps.
// R18: Software normally zeroes both first-order coefficients.
// R19: Second-order output is shifted sum of three input, two output terms.
// R20: Error code step is 8 mV, gain 125 LSB per volt.
// R21: Output saturates at 16-bit range or clamps, never wraps.
// R22: One output per sample; history shifts one place per sample.
`timescale 1ns/10ps
module cfc_filter_top #(
    parameter int PER_W = cfc_pkg::PER_W
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Error front end
    input wire logic signed [cfc_pkg::ERR_W-1:0] err_sample_i,
    input wire logic err_strobe_i,
    // Reference code
    input wire logic [cfc_pkg::DAC_W-1:0] ref_code_i,
    output logic [cfc_pkg::DAC_W-1:0] ref_dac_o,
    // Second-order coefficients and gain
    input wire logic signed [cfc_pkg::COEF_W-1:0] coef_b0_i,
    input wire logic signed [cfc_pkg::COEF_W-1:0] coef_b1_i,
    input wire logic signed [cfc_pkg::COEF_W-1:0] coef_b2_i,
    input wire logic signed [cfc_pkg::COEF_W-1:0] coef_a1_i,
    input wire logic signed [cfc_pkg::COEF_W-1:0] coef_a2_i,
    input wire logic [cfc_pkg::KS_W-1:0] kscale_i,
    // First-order coefficients
    input wire logic signed [cfc_pkg::COEF_W-1:0] first_order_zero_coef_i,
    input wire logic signed [cfc_pkg::COEF_W-1:0] first_order_pole_coef_i,
    // Clamps and kick-start
    input wire logic signed [cfc_pkg::OUT_W-1:0] clamp_hi_i,
    input wire logic signed [cfc_pkg::OUT_W-1:0] clamp_lo_i,
    input wire logic kick_start_i,
    // Modulator
    input wire logic [PER_W-1:0] switch_period_value_i,
    output logic pwm_o,
    output logic [cfc_pkg::PH_W-1:0] edge_phase_o,
    // Status
    output logic signed [cfc_pkg::OUT_W-1:0] filt_out_o,
    output logic filt_valid_o,
    output logic overrun_o
);
    import cfc_pkg::*;

    typedef struct packed {
        cfc_state_type st;
        logic sy1;
        logic sy2;
        logic sy3;
        logic stb;
        logic signed [ERR_W-1:0] err;
        logic signed [GIN_W-1:0] x1;
        logic signed [GIN_W-1:0] x2;
        logic signed [OUT_W-1:0] y1;
        logic signed [OUT_W-1:0] y2;
        logic signed [OUT_W-1:0] u;
        logic signed [OUT_W-1:0] u1;
        logic signed [OUT_W-1:0] v1;
        logic signed [OUT_W-1:0] filt;
        logic push;
        logic fvalid;
        logic ovr;
        logic [PER_W-1:0] ramp;
        logic [PER_W-1:0] coarse;
        logic [PH_W-1:0] phase;
        logic pwm;
        logic [DAC_W-1:0] dac;
    } cfc_core_state_type;

    cfc_core_state_type r_q;
    cfc_core_state_type r_d;

    logic signed [GIN_W-1:0] x0;
    logic buf_in_ready;
    logic buf_out_valid;
    logic buf_out_ready;
    logic [OUT_W-1:0] buf_out_data;
    logic stb_event;
    logic signed [ACC_W-1:0] acc;
    logic signed [WIDE_W-1:0] shifted;
    logic signed [WIDE_W-1:0] fo_sum;
    logic signed [OUT_W-1:0] lo;
    logic signed [OUT_W-1:0] hi;
    logic signed [OUT_W-1:0] y_new;
    logic signed [OUT_W-1:0] v_new;
    logic wrap;
    logic [OUT_W-2:0] duty_pos;
    logic [OUT_W-1+PER_W-1:0] edge_prod;
    logic [OUT_W-1:0] edge_fine;

    // Feed-forward term, rounded
    function automatic logic signed [ACC_W-1:0] num_term(
        input logic signed [GIN_W-1:0] x,
        input logic signed [COEF_W-1:0] c
    );
        logic signed [GIN_W+COEF_W-1:0] p;
        logic signed [PROD_W:0] r;
        p = x * c;
        r = {p[PROD_W-1], p[PROD_W-1:0]}; // R5
        r = r + (PROD_W+1)'(1 << (NUM_DROP - 1)); // R7
        num_term = ACC_W'(r >>> NUM_DROP); // R8
    endfunction

    // Feedback term, rounded
    function automatic logic signed [ACC_W-1:0] den_term(
        input logic signed [OUT_W-1:0] y,
        input logic signed [COEF_W-1:0] c
    );
        logic signed [OUT_W+COEF_W:0] p;
        p = y * c;
        p = p + (OUT_W+COEF_W+1)'(1 << (DEN_DROP - 1)); // R7
        den_term = ACC_W'(p >>> DEN_DROP); // R10
    endfunction

    // First-order term with fractional coefficient, rounded
    function automatic logic signed [WIDE_W-1:0] fo_term(
        input logic signed [OUT_W-1:0] y,
        input logic signed [COEF_W-1:0] c
    );
        logic signed [OUT_W+COEF_W:0] p;
        p = y * c;
        p = p + (OUT_W+COEF_W+1)'(1 << (FO_DROP - 1)); // R7
        fo_term = WIDE_W'(p >>> FO_DROP);
    endfunction

    // Clamp straight to the high and low clamps, which lie within 16 bits
    function automatic logic signed [OUT_W-1:0] limit(
        input logic signed [WIDE_W-1:0] v,
        input logic signed [OUT_W-1:0] l,
        input logic signed [OUT_W-1:0] h
    );
        logic signed [WIDE_W-1:0] t;
        t = v;
        if (t > WIDE_W'(h)) begin
            t = WIDE_W'(h);
        end
        if (t < WIDE_W'(l)) begin
            t = WIDE_W'(l);
        end
        limit = OUT_W'(t); // R21
    endfunction

    cfc_nl_gain u_gain (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .err_i(r_q.err),
        .gain_o(x0)
    );

    cfc_buf2 #(
        .WIDTH(OUT_W),
        .DEPTH(2)
    ) u_buf (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .in_valid_i(r_q.push),
        .in_ready_o(buf_in_ready),
        .in_data_i(r_q.filt),
        .out_valid_o(buf_out_valid),
        .out_ready_i(buf_out_ready),
        .out_data_o(buf_out_data)
    );

    always_comb begin
        r_d = r_q;
        r_d.sy1 = err_strobe_i;
        r_d.sy2 = r_q.sy1;
        r_d.sy3 = r_q.sy2;
        if (r_q.sy2 == r_q.sy3) begin
            r_d.stb = r_q.sy3;
        end
        stb_event = (r_q.sy2 == r_q.sy3) && r_q.sy3 && !r_q.stb;
        r_d.dac = ref_code_i; // R2
        r_d.fvalid = 1'b0;
        r_d.ovr = stb_event && (r_q.st != ST_IDLE);

        // Kick-start collapses both clamps onto the low limit
        lo = clamp_lo_i; // R17
        hi = kick_start_i ? clamp_lo_i : clamp_hi_i; // R17

        acc = num_term(x0, coef_b0_i)
            + num_term(r_q.x1, coef_b1_i)
            + num_term(r_q.x2, coef_b2_i)
            + den_term(r_q.y1, coef_a1_i)
            + den_term(r_q.y2, coef_a2_i); // R11 R19
        shifted = WIDE_W'(acc) <<< kscale_i; // R19
        shifted = (shifted + WIDE_W'(1 << (KS_DROP - 1))) >>> KS_DROP; // R9
        y_new = limit(shifted, lo, hi); // R6 R21

        fo_sum = WIDE_W'(r_q.u)
               + fo_term(r_q.u1, first_order_zero_coef_i)
               + fo_term(r_q.v1, first_order_pole_coef_i); // R16
        v_new = limit(fo_sum, lo, hi); // R17 R21

        // Free-running sequencer, no processor involvement
        case (r_q.st) // R15
            ST_IDLE: begin
                if (stb_event) begin
                    r_d.err = err_sample_i; // R1 R20
                    r_d.st = ST_GAIN;
                end
            end
            ST_GAIN: begin
                r_d.st = ST_SEC2;
            end
            ST_SEC2: begin
                r_d.x1 = x0; // R22
                r_d.x2 = r_q.x1; // R22
                r_d.y1 = y_new; // R22
                r_d.y2 = r_q.y1; // R22
                r_d.u = y_new;
                r_d.st = ST_SEC1;
            end
            ST_SEC1: begin
                r_d.u1 = r_q.u; // R22
                r_d.v1 = v_new; // R22
                r_d.filt = v_new; // R6
                r_d.fvalid = 1'b1;
                r_d.push = 1'b1;
                r_d.st = ST_PUSH;
            end
            ST_PUSH: begin
                if (buf_in_ready) begin
                    r_d.push = 1'b0;
                    r_d.st = ST_IDLE;
                end
            end
            default: begin
                r_d.push = 1'b0;
                r_d.st = ST_IDLE;
            end
        endcase

        // Ramp counter; new width taken at the end of a period
        wrap = (r_q.ramp >= switch_period_value_i - 1'b1)
            || (switch_period_value_i == '0);
        buf_out_ready = wrap;
        r_d.ramp = wrap ? '0 : r_q.ramp + 1'b1;
        duty_pos = buf_out_data[OUT_W-1] ? '0 : buf_out_data[OUT_W-2:0];
        edge_prod = duty_pos * switch_period_value_i; // R13
        edge_fine = OUT_W'(edge_prod >> EDGE_SHIFT); // R14
        if (wrap && buf_out_valid) begin
            r_d.coarse = PER_W'(edge_fine >> PH_W); // R13
            r_d.phase = edge_fine[PH_W-1:0]; // R14
        end
        r_d.pwm = r_d.ramp < r_d.coarse; // R13
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r_q <= '0;
            r_q.st <= ST_IDLE;
            r_q.dac <= DAC_RST;
            r_q.filt <= OUT_RST;
        end else begin
            r_q <= r_d;
        end
    end

    assign ref_dac_o = r_q.dac;
    assign pwm_o = r_q.pwm;
    assign edge_phase_o = r_q.phase;
    assign filt_out_o = r_q.filt;
    assign filt_valid_o = r_q.fvalid;
    assign overrun_o = r_q.ovr;
endmodule

// *** logic/cfc_pkg.sv ***
// Purpose: shared constants and types of the compensation filter
// Assumes: one 10 MHz reference clock
// Notes: all filter signals are two's-complement
package cfc_pkg;
    localparam int ERR_W = 6;
    localparam int GIN_W = 9;
    localparam int COEF_W = 12;
    localparam int PROD_W = 20;
    localparam int OUT_W = 16;
    localparam int DAC_W = 10;
    localparam int KS_W = 3;
    localparam int PER_W = 12;
    localparam int NUM_DROP = 3;
    localparam int KS_DROP = 3;
    localparam int DEN_DROP = 8;
    localparam int FO_DROP = 11;
    localparam int COEF_FRAC = 11;
    localparam int ACC_W = 24;
    localparam int WIDE_W = 32;
    localparam int REF_CLK_HZ = 10_000_000;
    localparam int REF_CLK_PERIOD_NS = 1_000_000_000 / REF_CLK_HZ;
    localparam int MOD_CLK_HZ = 250_000_000;
    localparam int MOD_PHASES = 16;
    localparam int PH_W = $clog2(MOD_PHASES);
    localparam int MOD_STEP_PS = 1_000_000 / ((MOD_CLK_HZ / 1_000_000)
                                * MOD_PHASES);
    localparam int PWM_GAIN_SHIFT = 15;
    localparam int EDGE_SHIFT = PWM_GAIN_SHIFT - PH_W;
    localparam int DAC_FULL_MV = 1600;
    localparam int ERR_LSB_PER_V = 125;
    localparam int ERR_MV_PER_LSB = 1000 / ERR_LSB_PER_V;
    localparam int NL_KNEE1 = 4;
    localparam int NL_KNEE2 = 12;
    localparam int NL_OFS2 = 8;
    localparam int NL_OFS3 = 56;
    localparam logic [DAC_W-1:0] DAC_RST = 10'h000;
    localparam logic signed [OUT_W-1:0] OUT_RST = 16'sh0000;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_GAIN = 5'h02,
        ST_SEC2 = 5'h04,
        ST_SEC1 = 5'h08,
        ST_PUSH = 5'h10
    } cfc_state_type;
endpackage

// *** logic/cfc_nl_gain.sv ***
// Purpose: nonlinear gain table, 6-bit error to 9-bit filter input
// Assumes: input held for one cycle before use
// Notes: read data registered, one cycle latency
`timescale 1ns/10ps
module cfc_nl_gain (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Lookup
    input wire logic signed [cfc_pkg::ERR_W-1:0] err_i,
    output logic signed [cfc_pkg::GIN_W-1:0] gain_o
);
    import cfc_pkg::*;

    typedef struct packed {
        logic signed [GIN_W-1:0] gain;
    } cfc_nl_state_type;

    cfc_nl_state_type r_q;
    cfc_nl_state_type r_d;
    logic signed [GIN_W-1:0] table_q [2**ERR_W];

    // Low slope near zero, steep slope for large errors
    function automatic logic signed [GIN_W-1:0] nl_map(input int e);
        int m;
        int g;
        m = (e < 0) ? -e : e;
        if (m <= NL_KNEE1) begin
            g = 2 * m;
        end else if (m <= NL_KNEE2) begin
            g = 4 * m - NL_OFS2;
        end else begin
            g = 8 * m - NL_OFS3;
        end
        nl_map = GIN_W'((e < 0) ? -g : g);
    endfunction

    generate
        for (genvar i = 0; i < 2**ERR_W; i++) begin : g_tab
            assign table_q[i] = nl_map((i >= 2**(ERR_W-1)) ?
                                       i - 2**ERR_W : i); // R4
        end
    endgenerate

    always_comb begin
        r_d = r_q;
        r_d.gain = table_q[$unsigned(err_i)]; // R3
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign gain_o = r_q.gain;
endmodule

// *** logic/cfc_buf2.sv ***
// Purpose: two-entry buffer between filter and modulator
// Assumes: valid/ready handshake on both sides
// Notes: full and empty are exact; no word is lost on stall
`timescale 1ns/10ps
module cfc_buf2 #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } cfc_buf_state_type;

    cfc_buf_state_type r_q;
    cfc_buf_state_type r_d;
    logic wr;
    logic rd;

    function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
        inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_comb begin
        r_d = r_q;
        wr = in_valid_i && (r_q.cnt != (AW+1)'(DEPTH));
        rd = out_ready_i && (r_q.cnt != '0);
        if (wr) begin
            r_d.mem[r_q.wp] = in_data_i;
            r_d.wp = inc(r_q.wp);
        end
        if (rd) begin
            r_d.rp = inc(r_q.rp);
        end
        r_d.cnt = r_q.cnt + (AW+1)'(wr) - (AW+1)'(rd);
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign in_ready_o = r_q.cnt != (AW+1)'(DEPTH);
    assign out_valid_o = r_q.cnt != '0;
    assign out_data_o = r_q.mem[r_q.rp];
endmodule

// *** dv/cfc_filter_properties.sv ***
// Purpose: port-level properties of the compensation filter
// Assumes: one clock domain, reset active high
// Notes: bound to every filter top instance
`timescale 1ns/10ps
module cfc_filter_checker #(
    parameter int PER_W = cfc_pkg::PER_W
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Inputs watched
    input wire logic err_strobe_i,
    input wire logic [cfc_pkg::DAC_W-1:0] ref_code_i,
    input wire logic signed [cfc_pkg::OUT_W-1:0] clamp_hi_i,
    input wire logic signed [cfc_pkg::OUT_W-1:0] clamp_lo_i,
    input wire logic kick_start_i,
    input wire logic [PER_W-1:0] switch_period_value_i,
    // Outputs watched
    input wire logic [cfc_pkg::DAC_W-1:0] ref_dac_o,
    input wire logic pwm_o,
    input wire logic signed [cfc_pkg::OUT_W-1:0] filt_out_o,
    input wire logic filt_valid_o,
    input wire logic overrun_o
);
    import cfc_pkg::*;
    logic [15:0] hi_cnt_q;
    logic [15:0] hi_cnt_d;
    // Length of the current high run of the pulse
    always_comb begin
        hi_cnt_d = pwm_o ? hi_cnt_q + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hi_cnt_q <= 16'h0000;
        end else begin
            hi_cnt_q <= hi_cnt_d;
        end
    end
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    a_dac_follow: assert property (
        !$past(rst_i) |-> ref_dac_o == $past(ref_code_i))
        else $error("reference output does not follow code");
    a_valid_gap: assert property (
        filt_valid_o |=> !filt_valid_o [*3])
        else $error("result pulse too long or too close");
    a_out_hold: assert property (
        !$past(rst_i) && !filt_valid_o |-> $stable(filt_out_o))
        else $error("result changed without a pulse");
    a_out_clamp: assert property (
        filt_valid_o |-> filt_out_o >= clamp_lo_i && filt_out_o <= clamp_hi_i)
        else $error("result outside the clamps");
    a_kick_low: assert property (
        filt_valid_o && kick_start_i |-> filt_out_o == clamp_lo_i)
        else $error("kick-start result not at low clamp");
    a_sample_answer: assert property (
        $rose(err_strobe_i) |-> ##[2:12] (filt_valid_o || overrun_o))
        else $error("sample got no answer");
    a_ovr_pulse: assert property (
        overrun_o |=> !overrun_o)
        else $error("overrun pulse too long");
    a_pwm_width: assert property (
        hi_cnt_q < 16'(switch_period_value_i))
        else $error("pulse high for a whole period");
endmodule
bind cfc_filter_top cfc_filter_checker #(.PER_W(PER_W)) u_chk (
    .ref_clk_i, .rst_i, .err_strobe_i, .ref_code_i, .clamp_hi_i,
    .clamp_lo_i, .kick_start_i, .switch_period_value_i, .ref_dac_o,
    .pwm_o, .filt_out_o, .filt_valid_o, .overrun_o
);

// *** dv/cfc_fe_model.sv ***
// Purpose: error front end and power stage stand-in
// Assumes: send is called at a falling edge
// Notes: error word inverted once its hold time is over, if hi plus lo exceeds 4
`timescale 1ns/10ps
module cfc_fe_model (
    // Clock
    input wire logic ref_clk_i,
    // Power stage drive
    input wire logic pwm_i,
    // Error sample
    output logic signed [cfc_pkg::ERR_W-1:0] err_sample_o,
    output logic err_strobe_o
);
    import cfc_pkg::*;
    int on_cycles = 0;
    initial begin
        err_sample_o = 6'h00;
        err_strobe_o = 1'b0;
    end
    // Switch-on time seen by the stage
    always @(posedge ref_clk_i) begin
        if (pwm_i === 1'b1) begin
            on_cycles <= on_cycles + 1;
        end
    end
    task automatic send(input int e, input int hi, input int lo);
        err_sample_o = e[ERR_W-1:0];
        err_strobe_o = 1'b1;
        repeat (hi) @(negedge ref_clk_i);
        err_strobe_o = 1'b0;
        repeat (lo - 1) @(negedge ref_clk_i);
        if (hi + lo > 4) begin
            err_sample_o = ~err_sample_o;
        end
        @(negedge ref_clk_i);
    endtask
endmodule

// *** dv/tb_top.sv ***
// Purpose: self-checking bench for the compensation filter
// Assumes: inputs change at falling edges
// Notes: reference model shadows every filter result
`timescale 1ns/10ps
module tb_top;
    import cfc_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [DAC_W-1:0] code, dac;
    logic signed [COEF_W-1:0] cb0, cb1, cb2, ca1, ca2, czc, cpc;
    logic [KS_W-1:0] ks;
    logic signed [OUT_W-1:0] c_hi, c_lo, f_out;
    logic kick, pwm, f_val, ovr_w, stb;
    logic [PER_W-1:0] per;
    logic [PH_W-1:0] phase;
    logic signed [ERR_W-1:0] err;
    int fails = 0, compares = 0, ovr = 0, seed = 32'h763A41E7;
    int xh1 = 0, xh2 = 0, yh1 = 0, yh2 = 0, v1 = 0, e, w, on0;
    int exp_q[$];
    always #50 ref_clk_i = ~ref_clk_i;
    cfc_filter_top #(.PER_W(PER_W)) uut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .err_sample_i(err),
        .err_strobe_i(stb), .ref_code_i(code), .ref_dac_o(dac),
        .coef_b0_i(cb0), .coef_b1_i(cb1), .coef_b2_i(cb2),
        .coef_a1_i(ca1), .coef_a2_i(ca2), .kscale_i(ks),
        .first_order_zero_coef_i(czc), .first_order_pole_coef_i(cpc),
        .clamp_hi_i(c_hi), .clamp_lo_i(c_lo), .kick_start_i(kick),
        .switch_period_value_i(per), .pwm_o(pwm), .edge_phase_o(phase),
        .filt_out_o(f_out), .filt_valid_o(f_val), .overrun_o(ovr_w)
    );
    cfc_fe_model fe (
        .ref_clk_i(ref_clk_i), .pwm_i(pwm), .err_sample_o(err),
        .err_strobe_o(stb)
    );
    function automatic int rnd(int v, int s);
        return (v + (1 <<< (s - 1))) >>> s;
    endfunction
    function automatic int lim(int v, int lo, int hi);
        return v < lo ? lo : (v > hi ? hi : v);
    endfunction
    function automatic int nl(int e);
        int m;
        m = e < 0 ? -e : e;
        m = m <= NL_KNEE1 ? 2 * m
            : (m <= NL_KNEE2 ? 4 * m - NL_OFS2 : 8 * m - NL_OFS3);
        return e < 0 ? -m : m;
    endfunction
    task automatic model(input int e);
        int x, y, v;
        x = nl(e);
        y = rnd(x * cb0, 3) + rnd(xh1 * cb1, 3) + rnd(xh2 * cb2, 3);
        y = y + rnd(yh1 * ca1, 8) + rnd(yh2 * ca2, 8);
        y = lim(lim(rnd(y <<< ks, 3), -32768, 32767), c_lo, c_hi);
        v = y + rnd(czc * yh1, 11) + rnd(cpc * v1, 11);
        v = lim(lim(v, -32768, 32767), c_lo, c_hi);
        if (kick) begin
            y = c_lo;
            v = c_lo;
        end
        xh2 = xh1;
        xh1 = x;
        yh2 = yh1;
        yh1 = y;
        v1 = v;
        exp_q.push_back(v);
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        compares++;
        if (seen !== expv) begin
            fails++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, expv);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(negedge ref_clk_i) begin
        if (ovr_w === 1'b1) begin
            ovr++;
        end
        if (f_val === 1'b1) begin
            check(f_out, exp_q.size() ? exp_q.pop_front() : 32'hBAD00000);
        end
    end
    initial begin
        repeat (8000) @(posedge ref_clk_i);
        fails++;
        end_sim();
    end
    initial begin
        code = 10'h000;
        {cb0, cb1, cb2, ca1, ca2, czc, cpc} = '0;
        {ks, kick} = '0;
        c_hi = 16'h07D0;
        c_lo = 16'hF830;
        per = 12'h004;
        repeat (6) @(negedge ref_clk_i);
        check(f_out, 32'h00000000);
        rst_i = 1'b0;
        code = DAC_W'($random(seed));
        @(negedge ref_clk_i);
        check(dac, code);
        for (int t = 0; t < 4; t++) begin
            // 0: second order, 1: with first order, 2: saturation, 3: sweep
            cb0 = COEF_W'(t == 3 ? 64 : (t == 2 ? 2000 : $random(seed) % 300));
            cb1 = COEF_W'(t == 3 ? 0 : (t == 2 ? 2000 : $random(seed) % 300));
            cb2 = COEF_W'(t == 3 ? 0 : (t == 2 ? 2000 : $random(seed) % 300));
            ca1 = COEF_W'(t >= 2 ? 0 : $random(seed) % 200);
            ca2 = COEF_W'(t >= 2 ? 0 : $random(seed) % 200);
            czc = COEF_W'(t == 1 ? $random(seed) % 512 : 0);
            cpc = COEF_W'(t == 1 ? $random(seed) % 512 : 0);
            ks = KS_W'(t == 3 ? 0 : (t == 2 ? 2 : $random(seed) & 1));
            c_hi = OUT_W'(t >= 2 ? 32767 : 2000);
            c_lo = OUT_W'(t >= 2 ? -32768 : -2000);
            for (int n = 0; n < (t == 3 ? 64 : 12); n++) begin
                e = t == 3 ? n - 32 : $random(seed) % 32;
                code = DAC_W'($random(seed));
                model(e);
                fe.send(e, 4, 6);
            end
            $display("test %0d done", t);
        end
        e = $random(seed) % 31;
        model(e);
        // First pulse two cycles wide, second four; second rise lands in the busy window
        fe.send(e, 2, 2);
        fe.send(-e, 4, 6);
        check(ovr, 1);
        $display("test overrun done");
        per = 12'h190;
        kick = 1'b1;
        for (int k = 0; k < 2; k++) begin
            c_lo = OUT_W'(k ? -5000 : 16000);
            c_hi = c_lo;
            model(0);
            fe.send(0, 4, 6);
            repeat (900) @(negedge ref_clk_i);
            on0 = fe.on_cycles;
            repeat (400) @(negedge ref_clk_i);
            w = c_lo > 0 ? c_lo * per : 0;
            check(fe.on_cycles - on0, w >>> PWM_GAIN_SHIFT);
            check(phase, (w >>> EDGE_SHIFT) & 15);
            $display("test modulator %0d done", k);
        end
        check(exp_q.size(), 0);
        end_sim();
    end
endmodule
